// file: hdl/flash_host_defines.vh
// constants shared by the flash host controller files
// assumes a 40 MHz clock and a parallel flash reached over its own pins
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH

// ********************************************************
// clock and timing
// ********************************************************
`define CLK_PERIOD_NS 25
`define ADDRESS_ACCESS_TIME_NS 100
`define RESET_PULSE_MIN_NS 500
`define RESET_RECOVERY_NS 500
`define WRITE_PULSE_NS 50
`define ACCEL_SETTLE_NS 250
`define BUSY_SETTLE_NS 100
// least times round up to whole cycles
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDRESS_ACCESS_CYC `CEIL_CYC(`ADDRESS_ACCESS_TIME_NS)
`define RESET_PULSE_CYC `CEIL_CYC(`RESET_PULSE_MIN_NS)
`define RESET_RECOVERY_CYC `CEIL_CYC(`RESET_RECOVERY_NS)
`define WRITE_PULSE_CYC `CEIL_CYC(`WRITE_PULSE_NS)
`define ACCEL_SETTLE_CYC `CEIL_CYC(`ACCEL_SETTLE_NS)
`define BUSY_SETTLE_CYC `CEIL_CYC(`BUSY_SETTLE_NS)
`define SYNC_CYC 2

// ********************************************************
// register map of the controller
// ********************************************************
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_ABORT 8'h14

// command register fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_ACCEL_BIT 3

// operation codes
`define OP_NONE 3'h0
`define OP_READ 3'h1
`define OP_PROGRAM 3'h2
`define OP_ERASE 3'h3
`define OP_AUTOSELECT 3'h4
`define OP_RETURN_READ 3'h5

// status register bits
`define ST_BUSY 0
`define ST_ACCEL 1
`define ST_AUTOSELECT 2
`define ST_RETRIED 3
`define ST_READY 4
`define ST_UNALIGNED 5

// ********************************************************
// flash bus command words
// ********************************************************
`define FL_UNLOCK_ADDR1 22'h000555
`define FL_UNLOCK_ADDR2 22'h0002AA
`define FL_UNLOCK_DATA1 16'h00AA
`define FL_UNLOCK_DATA2 16'h0055
`define FL_PROGRAM_DATA 16'h00A0
`define FL_ERASE_SETUP_DATA 16'h0080
`define FL_SECTOR_ERASE_DATA 16'h0030
`define FL_AUTOSELECT_DATA 16'h0090
`define FL_RETURN_READ_DATA 16'h00F0
`define FL_PAGE_MASK 22'h00000F

`endif

// file: hdl/sync_two_flop.v
// two flip-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clock
`timescale 1ns/10ps
module sync_two_flop #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clock,
  input wire srst,
  // asynchronous in, synchronous out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] first_reg;
  reg [WIDTH-1:0] second_reg;

  // first stage only feeds the second
  always @(posedge clock) begin
    if (srst) begin
      first_reg <= {WIDTH{1'b0}};
      second_reg <= {WIDTH{1'b0}};
    end else begin
      first_reg <= async_in;
      second_reg <= first_reg;
    end
  end

  assign sync_out = second_reg;

endmodule // sync_two_flop

// file: hdl/flash_mode_host.v
// host controller driving a parallel flash through its pins
// assumes a register port from software and the flash on the pins below
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_mode_host (
  // clock and reset
  input wire clock,
  input wire srst,
  // software register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  // flash control pins
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg flash_reset_n,
  output reg accel_high_voltage,
  output reg [21:0] flash_addr,
  // flash data pins, split into in, out and enable
  input wire [15:0] flash_dq_in,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  // flash ready/busy pin, low while busy
  input wire flash_ready
);

  // ********************************************************
  // states and synchronised pins
  // ********************************************************
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_HV_UP = 9'h002;
  localparam [8:0] S_WR_LOW = 9'h004;
  localparam [8:0] S_WR_HIGH = 9'h008;
  localparam [8:0] S_RD_WAIT = 9'h010;
  localparam [8:0] S_POLL = 9'h020;
  localparam [8:0] S_HV_DOWN = 9'h040;
  localparam [8:0] S_RST_LOW = 9'h080;
  localparam [8:0] S_RST_REC = 9'h100;

  localparam [31:0] ACC_FULL = `ADDRESS_ACCESS_CYC + `SYNC_CYC;
  localparam [31:0] RST_FULL = `RESET_PULSE_CYC;
  localparam [31:0] REC_FULL = `RESET_RECOVERY_CYC;
  localparam [31:0] WE_FULL = `WRITE_PULSE_CYC;
  localparam [31:0] HV_FULL = `ACCEL_SETTLE_CYC;
  localparam [31:0] BUSY_FULL = `BUSY_SETTLE_CYC + `SYNC_CYC;
  // wait counts cut to the 12-bit cycle counter on purpose
  localparam [11:0] ACC_WAIT = ACC_FULL[11:0];
  localparam [11:0] RST_WAIT = RST_FULL[11:0];
  localparam [11:0] REC_WAIT = REC_FULL[11:0];
  localparam [11:0] WE_WAIT = WE_FULL[11:0];
  localparam [11:0] HV_WAIT = HV_FULL[11:0];
  localparam [11:0] BUSY_WAIT = BUSY_FULL[11:0];

  wire [16:0] pins_sync;
  wire [15:0] dq_sync;
  wire ready_sync;

  // every pin input passes two flops
  sync_two_flop #(.WIDTH(17)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({flash_ready, flash_dq_in}),
    .sync_out(pins_sync)
  );
  assign dq_sync = pins_sync[15:0];
  assign ready_sync = pins_sync[16];

  // ********************************************************
  // command sequences
  // ********************************************************
  // number of write cycles an operation needs
  function [2:0] seq_len;
    input [2:0] op;
    input accel;
    begin
      case (op)
        `OP_PROGRAM: seq_len = accel ? 3'd2 : 3'd4;
        `OP_ERASE: seq_len = 3'd6;
        `OP_AUTOSELECT: seq_len = 3'd3;
        `OP_RETURN_READ: seq_len = 3'd1;
        default: seq_len = 3'd0;
      endcase
    end
  endfunction

  // address and data of one write cycle
  function [37:0] seq_word;
    input [2:0] op;
    input accel;
    input [2:0] step;
    input [21:0] target;
    input [15:0] wdata;
    begin
      seq_word = {`FL_UNLOCK_ADDR1, `FL_RETURN_READ_DATA};
      if (op == `OP_PROGRAM && accel) begin
        // bypass sequence: program word then data
        if (step == 3'd0) begin
          seq_word = {`FL_UNLOCK_ADDR1, `FL_PROGRAM_DATA};
        end else begin
          seq_word = {target, wdata};
        end
      end else if (op != `OP_RETURN_READ) begin
        case (step)
          3'd0: seq_word = {`FL_UNLOCK_ADDR1, `FL_UNLOCK_DATA1};
          3'd1: seq_word = {`FL_UNLOCK_ADDR2, `FL_UNLOCK_DATA2};
          3'd2: begin
            if (op == `OP_PROGRAM) begin
              seq_word = {`FL_UNLOCK_ADDR1, `FL_PROGRAM_DATA};
            end else if (op == `OP_ERASE) begin
              seq_word = {`FL_UNLOCK_ADDR1, `FL_ERASE_SETUP_DATA};
            end else begin
              seq_word = {`FL_UNLOCK_ADDR1, `FL_AUTOSELECT_DATA};
            end
          end
          3'd3: begin
            if (op == `OP_PROGRAM) begin
              seq_word = {target, wdata};
            end else begin
              seq_word = {`FL_UNLOCK_ADDR1, `FL_UNLOCK_DATA1};
            end
          end
          3'd4: seq_word = {`FL_UNLOCK_ADDR2, `FL_UNLOCK_DATA2};
          default: seq_word = {target, `FL_SECTOR_ERASE_DATA};
        endcase
      end
    end
  endfunction

  // ********************************************************
  // controller state
  // ********************************************************
  reg [8:0] state_reg;
  reg [11:0] count_reg;
  reg [2:0] step_reg;
  reg [2:0] op_reg;
  reg accel_reg;
  reg [21:0] target_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg autoselect_reg;
  reg retry_reg;
  reg retried_reg;
  reg unaligned_reg;

  wire cmd_write = reg_write && reg_addr == `REG_CMD;
  wire abort_write = reg_write && reg_addr == `REG_ABORT;
  wire [2:0] cmd_op = reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB];
  wire cmd_accel = reg_wdata[`CMD_ACCEL_BIT] && cmd_op == `OP_PROGRAM;
  wire [2:0] cur_len = seq_len(op_reg, accel_reg);
  wire [37:0] cur_word = seq_word(op_reg, accel_reg, step_reg, target_reg, wdata_reg);
  wire busy = state_reg != S_IDLE;
  wire long_op = op_reg == `OP_PROGRAM || op_reg == `OP_ERASE;

  // sequencer driving the flash pins
  always @(posedge clock) begin
    if (srst) begin
      state_reg <= S_IDLE;
      count_reg <= 12'h000;
      step_reg <= 3'h0;
      op_reg <= `OP_NONE;
      accel_reg <= 1'b0;
      target_reg <= 22'h000000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      autoselect_reg <= 1'b0;
      retry_reg <= 1'b0;
      retried_reg <= 1'b0;
      unaligned_reg <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b1;
      accel_high_voltage <= 1'b0;
      flash_addr <= 22'h000000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      // operands are taken while idle
      if (!busy && reg_write && reg_addr == `REG_ADDR) begin
        target_reg <= reg_wdata[21:0];
      end
      if (!busy && reg_write && reg_addr == `REG_WDATA) begin
        wdata_reg <= reg_wdata[15:0];
      end
      if (abort_write) begin
        // reset pulse cuts any operation short
        retry_reg <= busy && long_op && state_reg != S_RST_LOW && state_reg != S_RST_REC;
        accel_high_voltage <= 1'b0;
        flash_reset_n <= 1'b0;
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
        flash_dq_oe <= 1'b0;
        count_reg <= 12'h000;
        state_reg <= S_RST_LOW;
      end else begin
        case (state_reg)
          S_IDLE: begin
            count_reg <= 12'h000;
            step_reg <= 3'h0;
            if (cmd_write && cmd_op != `OP_NONE && cmd_op <= `OP_RETURN_READ) begin
              op_reg <= cmd_op;
              accel_reg <= cmd_accel;
              retried_reg <= 1'b0;
              if (cmd_op == `OP_PROGRAM) begin
                // flag a program that starts inside a page
                unaligned_reg <= (target_reg & `FL_PAGE_MASK) != 22'h000000;
              end
              if (cmd_accel) begin
                accel_high_voltage <= 1'b1;
                state_reg <= S_HV_UP;
              end else if (cmd_op == `OP_READ) begin
                flash_addr <= target_reg;
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                state_reg <= S_RD_WAIT;
              end else begin
                state_reg <= S_WR_LOW;
              end
            end
          end
          S_HV_UP: begin
            // let the high voltage settle before the first write
            count_reg <= count_reg + 12'h001;
            if (count_reg == HV_WAIT - 12'h001) begin
              count_reg <= 12'h000;
              state_reg <= S_WR_LOW;
            end
          end
          S_WR_LOW: begin
            // drive data only while output enable is high
            flash_oe_n <= 1'b1;
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_we_n <= 1'b0;
            flash_addr <= cur_word[37:16];
            flash_dq_out <= cur_word[15:0];
            count_reg <= count_reg + 12'h001;
            if (count_reg == WE_WAIT) begin
              count_reg <= 12'h000;
              flash_we_n <= 1'b1;
              state_reg <= S_WR_HIGH;
            end
          end
          S_WR_HIGH: begin
            count_reg <= count_reg + 12'h001;
            if (count_reg == WE_WAIT - 12'h001) begin
              count_reg <= 12'h000;
              flash_dq_oe <= 1'b0;
              if (step_reg != cur_len - 3'd1) begin
                step_reg <= step_reg + 3'd1;
                state_reg <= S_WR_LOW;
              end else begin
                flash_ce_n <= 1'b1;
                if (op_reg == `OP_AUTOSELECT) begin
                  autoselect_reg <= 1'b1;
                  state_reg <= S_IDLE;
                end else if (op_reg == `OP_RETURN_READ) begin
                  autoselect_reg <= 1'b0;
                  state_reg <= S_IDLE;
                end else begin
                  state_reg <= S_POLL;
                end
              end
            end
          end
          S_RD_WAIT: begin
            // full access time every read, then sample the synced bus
            count_reg <= count_reg + 12'h001;
            if (count_reg == ACC_WAIT) begin
              if (autoselect_reg) begin
                rdata_reg <= {8'h00, dq_sync[7:0]};
              end else begin
                rdata_reg <= dq_sync;
              end
              flash_ce_n <= 1'b1;
              flash_oe_n <= 1'b1;
              count_reg <= 12'h000;
              state_reg <= S_IDLE;
            end
          end
          S_POLL: begin
            // deselected device keeps working; wait for ready
            if (count_reg != BUSY_WAIT) begin
              count_reg <= count_reg + 12'h001;
            end else if (ready_sync) begin
              count_reg <= 12'h000;
              if (accel_reg) begin
                accel_high_voltage <= 1'b0;
                state_reg <= S_HV_DOWN;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_HV_DOWN: begin
            // device falls back to normal mode as the voltage goes
            count_reg <= count_reg + 12'h001;
            if (count_reg == HV_WAIT - 12'h001) begin
              count_reg <= 12'h000;
              accel_reg <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
          S_RST_LOW: begin
            count_reg <= count_reg + 12'h001;
            if (count_reg == RST_WAIT - 12'h001) begin
              count_reg <= 12'h000;
              flash_reset_n <= 1'b1;
              autoselect_reg <= 1'b0;
              state_reg <= S_RST_REC;
            end
          end
          S_RST_REC: begin
            count_reg <= count_reg + 12'h001;
            if (count_reg == REC_WAIT - 12'h001) begin
              count_reg <= 12'h000;
              step_reg <= 3'h0;
              if (retry_reg) begin
                // reissue the interrupted program or erase
                retry_reg <= 1'b0;
                retried_reg <= 1'b1;
                if (accel_reg) begin
                  accel_high_voltage <= 1'b1;
                  state_reg <= S_HV_UP;
                end else begin
                  state_reg <= S_WR_LOW;
                end
              end else begin
                accel_reg <= 1'b0;
                state_reg <= S_IDLE;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ********************************************************
  // register read port
  // ********************************************************
  // read data stand the cycle after the strobe
  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      case (reg_addr)
        `REG_CMD: reg_rdata <= {28'h0000000, accel_reg, op_reg};
        `REG_ADDR: reg_rdata <= {10'h000, target_reg};
        `REG_WDATA: reg_rdata <= {16'h0000, wdata_reg};
        `REG_RDATA: reg_rdata <= {16'h0000, rdata_reg};
        `REG_STATUS: reg_rdata <= {26'h0000000, unaligned_reg, ready_sync, retried_reg,
          autoselect_reg, accel_high_voltage, busy};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // flash_mode_host

// file: testbench/flash_mode_host_sva.sv
// concurrent checks on the flash host controller pins and register port
// assumes a bind onto flash_mode_host, one clock and a synchronous reset
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_mode_host_sva (
  // clock and reset
  input wire clock,
  input wire srst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  // flash pins
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_reset_n,
  input wire accel_high_voltage,
  input wire [21:0] flash_addr,
  input wire [15:0] flash_dq_in,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe,
  input wire flash_ready
);
  reg [7:0] rst_low_reg;
  reg [3:0] accel_wr_reg;
  reg we_d_reg;
  // counts flash reset low cycles and write cycles under high voltage
  always @(posedge clock) begin
    if (srst) begin
      rst_low_reg <= 8'h00;
      accel_wr_reg <= 4'h0;
      we_d_reg <= 1'b1;
    end else begin
      rst_low_reg <= flash_reset_n ? 8'h00 : rst_low_reg + 8'h01;
      we_d_reg <= flash_we_n;
      if (!accel_high_voltage)
        accel_wr_reg <= 4'h0;
      else if (we_d_reg && !flash_we_n)
        accel_wr_reg <= accel_wr_reg + 4'h1;
    end
  end
  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  chk_accel_two_writes:
    assert property ($fell(accel_high_voltage) |-> accel_wr_reg == 4'h2)
      else $error("accelerated program did not use two write cycles");
  chk_accel_no_read:
    assert property (accel_high_voltage |-> flash_oe_n)
      else $error("read strobe low under high voltage");
  chk_accel_settle:
    assert property ($rose(accel_high_voltage) |-> flash_we_n [*8])
      else $error("write started too soon after high voltage");
  chk_we_pulse_len:
    assert property ($fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n)
      else $error("write strobe low time wrong");
  chk_write_framing:
    assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write cycle framing wrong");
  chk_dq_drive_oe:
    assert property (flash_dq_oe |-> flash_oe_n)
      else $error("data driven while flash outputs enabled");
  chk_write_hold:
    assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr)
      && $stable(flash_dq_out)) else $error("address or data moved in write");
  chk_reset_pulse:
    assert property ($rose(flash_reset_n) |-> rst_low_reg >= `RESET_PULSE_CYC)
      else $error("flash reset pulse too short");
  chk_rdata_quiet:
    assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
  cover property ($rose(accel_high_voltage));
  cover property ($fell(flash_reset_n));
  cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule // flash_mode_host_sva

bind flash_mode_host flash_mode_host_sva chk (.clock, .srst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
  .accel_high_voltage, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ready);

// file: testbench/flash_dev_model.sv
// behavioural model of the parallel flash seen from its pins
// assumes host pins change on the same clock; erase acts when busy ends
`timescale 1ns/10ps
module flash_dev_model #(
  parameter [7:0] AUTO_CODE = 8'h5A // arbitrary autoselect code
) (
  // clock and pace
  input wire clock,
  input wire slow,
  // control pins
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire reset_n,
  input wire protect_accel_pin,
  // address and data
  input wire [21:0] addr,
  input wire [15:0] dq_host,
  output reg [15:0] dq_dev = 16'h0000,
  output wire ready
);
  logic [15:0] mem [logic [21:0]];
  bit ecc_off [0:262143];
  bit prog_seen [0:262143];
  logic [21:0] wa, addr_d;
  logic [15:0] wd;
  logic [6:0] esec;
  logic we_d = 1'b1, auto_mode = 1'b0, prog_next = 1'b0, erase_arm = 1'b0, erase_pend = 1'b0;
  int step = 0;
  int busy = 0;
  // only a driven logic high counts as the high voltage; an open or unknown pin does not
  wire accel_hv = (protect_accel_pin === 1'b1);
  // command decode on the end of each write cycle, program and erase
  always @(posedge clock) begin
    we_d <= we_n;
    if (!we_n) begin
      wa <= addr;
      wd <= dq_host;
    end
    if (!reset_n) begin
      step <= 0;
      busy <= 0;
      auto_mode <= 1'b0;
      prog_next <= 1'b0;
      erase_arm <= 1'b0;
      erase_pend <= 1'b0;
    end else begin
      if (busy > 0)
        busy <= busy - 1;
      if (busy == 1 && erase_pend) begin
        erase_pend <= 1'b0;
        foreach (mem[a]) if (a[21:15] == esec) mem[a] = 16'hFFFF;
        for (int p = 0; p < 2048; p++) begin
          ecc_off[{esec, p[10:0]}] = 1'b0;
          prog_seen[{esec, p[10:0]}] = 1'b0;
        end
      end
      if (we_n && !we_d && !ce_n) begin
        step <= 0;
        if (prog_next) begin
          prog_next <= 1'b0;
          if (prog_seen[wa[21:4]]) ecc_off[wa[21:4]] = 1'b1;
          prog_seen[wa[21:4]] = 1'b1;
          mem[wa] = wd;
          busy <= slow ? 40 : 4;
        end else if (wd == 16'h00F0)
          auto_mode <= 1'b0;
        else if (wd == 16'h00A0 && (step == 2 || accel_hv))
          prog_next <= 1'b1;
        else if (step == 2 && wd == 16'h0090)
          auto_mode <= 1'b1;
        else if (step == 2 && erase_arm && wd == 16'h0030) begin
          erase_arm <= 1'b0;
          erase_pend <= 1'b1;
          esec <= wa[21:15];
          busy <= slow ? 40 : 4;
        end else if (step == 2 && wd == 16'h0080)
          erase_arm <= 1'b1;
        else if (step == 0 && wd == 16'h00AA)
          step <= 1;
        else if (step == 1 && wd == 16'h0055)
          step <= 2;
      end
    end
  end
  // read path: a changing pattern while floated or the address is new
  always @(posedge clock) begin
    addr_d <= addr;
    if (ce_n || oe_n || !reset_n || addr != addr_d)
      dq_dev <= ~dq_dev;
    else if (auto_mode)
      dq_dev <= {~dq_dev[15:8], AUTO_CODE};
    else
      dq_dev <= mem.exists(addr) ? mem[addr] : 16'hFFFF;
  end
  assign ready = (busy == 0);
endmodule // flash_dev_model

// file: testbench/flash_mode_host_tb.sv
// self-checking bench for the flash host controller
// assumes the flash model and the checker are compiled before it
`timescale 1ns/10ps
`include "flash_host_defines.vh"
module flash_mode_host_tb;
  reg clock = 1'b0;
  reg srst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg slow = 1'b0;
  reg [31:0] d;
  wire [31:0] reg_rdata;
  wire flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, accel_high_voltage;
  wire flash_dq_oe, flash_ready;
  wire [21:0] flash_addr;
  wire [15:0] flash_dq_in, flash_dq_out, dev_q;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int we_falls = 0;
  flash_mode_host dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .accel_high_voltage,
    .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ready);
  flash_dev_model model (.clock(clock), .slow(slow), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .reset_n(flash_reset_n), .protect_accel_pin(accel_high_voltage),
    .addr(flash_addr), .dq_host(flash_dq_out), .dq_dev(dev_q), .ready(flash_ready));
  // data wire level: the host wins while it drives
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dev_q;
  // clock, write strobe count and hang guard
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(negedge flash_we_n) we_falls++;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up;
    end
  end
  // ********************************************************
  // bus and compare tasks
  // ********************************************************
  task check(input string name, input [31:0] exp, input [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wait_idle;
    d = 32'h1;
    for (int n = 0; n < 400 && d[`ST_BUSY]; n++) rd(`REG_STATUS, d);
    check("busy clears", 32'h0, {31'h0, d[`ST_BUSY]});
  endtask
  task run_op(input [2:0] op, input accel, input [21:0] a, input [15:0] v);
    wr(`REG_ADDR, {10'h0, a});
    wr(`REG_WDATA, {16'h0, v});
    wr(`REG_CMD, {28'h0, accel, op});
    wait_idle;
  endtask
  task read_chk(input [21:0] a, input [31:0] exp);
    run_op(`OP_READ, 1'b0, a, 16'h0);
    rd(`REG_RDATA, d);
    check("read data", exp, d);
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task s_program;
    // let the ready pin pass its synchroniser first
    repeat (2) @(posedge clock);
    rd(`REG_STATUS, d);
    check("status after reset", 32'h10, d);
    rd(8'h40, d);
    check("unmapped read", 32'h0, d);
    wr(`REG_CMD, 32'h6);
    rd(`REG_STATUS, d);
    check("unknown op ignored", 32'h10, d);
    we_falls = 0;
    run_op(`OP_PROGRAM, 1'b0, 22'h000100, 16'h1234);
    check("normal write cycles", 32'd4, we_falls);
    read_chk(22'h000100, 32'h1234);
    run_op(`OP_PROGRAM, 1'b0, 22'h000103, 16'h5678);
    rd(`REG_STATUS, d);
    check("unaligned flag", 32'h1, {31'h0, d[`ST_UNALIGNED]});
    check("page code off", 32'h1, {31'h0, model.ecc_off[18'h10]});
    read_chk(22'h000103, 32'h5678);
    run_op(`OP_ERASE, 1'b0, 22'h000100, 16'h0);
    read_chk(22'h000100, 32'hFFFF);
    check("page code back", 32'h0, {31'h0, model.ecc_off[18'h10]});
  endtask
  task s_accel;
    slow = 1'b1;
    we_falls = 0;
    run_op(`OP_PROGRAM, 1'b1, 22'h000200, 16'hBEEF);
    check("accel write cycles", 32'd2, we_falls);
    rd(`REG_STATUS, d);
    check("accel voltage off", 32'h0, {31'h0, d[`ST_ACCEL]});
    read_chk(22'h000200, 32'hBEEF);
    run_op(`OP_AUTOSELECT, 1'b0, 22'h000000, 16'h0);
    rd(`REG_STATUS, d);
    check("autoselect flag", 32'h1, {31'h0, d[`ST_AUTOSELECT]});
    read_chk(22'h000000, {24'h0, model.AUTO_CODE});
    run_op(`OP_RETURN_READ, 1'b0, 22'h000000, 16'h0);
    read_chk(22'h000200, 32'hBEEF);
  endtask
  task s_abort;
    wr(`REG_ADDR, 32'h200);
    wr(`REG_CMD, {29'h0, `OP_ERASE});
    repeat (40) @(posedge clock);
    wr(`REG_ABORT, 32'h0);
    repeat (45) @(posedge clock);
    wait_idle;
    rd(`REG_STATUS, d);
    check("reissue flag", 32'h1, {31'h0, d[`ST_RETRIED]});
    read_chk(22'h000200, 32'hFFFF);
  endtask
  task wrap_up;
    $display("comparisons %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    s_program;
    s_accel;
    s_abort;
    wrap_up;
  end
endmodule // flash_mode_host_tb
